/* inc/wake_pm_regs.svh */
// Register offsets, fields and constants of the wake block
`ifndef WAKE_PM_REGS_SVH
`define WAKE_PM_REGS_SVH
`define PMCS_OFS        8'h00
`define GCS_OFS         8'h04
`define WCFG_OFS        8'h08
`define SA0_OFS         8'h0C
`define SA1_OFS         8'h10
`define SA2_OFS         8'h14
`define PMCS_STATE_LSB  0
`define PMCS_EN_BIT     8
`define EVT_STAT_BIT    15
`define GCS_SAW_BIT     0
`define GCS_LP_BIT      1
`define GCS_ARM_BIT     2
`define WCFG_ADDR_BIT   0
`define WCFG_PAT_BIT    1
`define EE_WAKE_WORD    6'h0A
`define EE_WAKE_BIT     5
`define EE_SA_LAST      6'h02
`define SYNC_BYTE       8'hFF
`define SYNC_COUNT      3'h6
`define SA_COPIES_BYTES 7'h60
`define SA_BYTES        3'h6
`endif

/* inc/wake_pm_pkg.sv */
// Types shared by the wake block
package wake_pm_pkg;
  typedef enum logic [1:0] {
    PS_D0 = 2'h0, PS_D1 = 2'h1, PS_D2 = 2'h2, PS_D3 = 2'h3
  } pm_state_t;
  typedef enum logic [2:0] {
    SCAN_IDLE = 3'h1, SCAN_SYNC = 3'h2, SCAN_ADDR = 3'h4
  } scan_state_t;
endpackage

/* design/station_addr_store.sv */
// Three-word station address memory with registered read
`timescale 1ns/1ns
`include "wake_pm_regs.svh"
module station_addr_store (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_word,
  input  wire logic [15:0] wr_data,
  // Read data
  output logic      [47:0] addr_q
);
  logic [15:0] mem_reg  [3];
  logic [15:0] mem_next [3];
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : word
      always_comb begin
        mem_next[g] = mem_reg[g];
        if (wr_en && wr_word == 2'(g)) begin
          mem_next[g] = wr_data;
        end
      end
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          mem_reg[g] <= 16'h0000;
        end else begin
          mem_reg[g] <= mem_next[g];
        end
      end
    end
  endgenerate
  // Read side registered so downstream timing starts at a flop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_q <= 48'h000000000000;
    end else begin
      addr_q <= {mem_reg[2], mem_reg[1], mem_reg[0]};
    end
  end
endmodule

/* design/pattern_matcher.sv */
// Scanner for six sync bytes then sixteen station address copies
`timescale 1ns/1ns
`include "wake_pm_regs.svh"
module pattern_matcher (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Received byte stream
  input  wire logic        rx_sof,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_eof,
  input  wire logic        rx_crc_ok,
  input  wire logic        addr_pass,
  input  wire logic [47:0] station_address,
  // One-cycle match pulse after a good frame end
  output logic             match
);
  wake_pm_pkg::scan_state_t st_reg, st_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [6:0] idx_reg, idx_next;
  logic [2:0] sel_reg, sel_next;
  logic       found_reg, found_next;
  logic       match_next;

  function automatic logic [7:0] sa_byte(input logic [47:0] sa,
                                         input logic [2:0] sel);
    sa_byte = sa[{sel, 3'h0} +: 8];
  endfunction

  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    idx_next   = idx_reg;
    sel_next   = sel_reg;
    found_next = found_reg;
    match_next = rx_eof & found_reg & rx_crc_ok & addr_pass;
    if (rx_sof) begin
      st_next    = wake_pm_pkg::SCAN_IDLE;
      cnt_next   = 3'h0;
      found_next = 1'b0;
    end else if (rx_valid && !found_reg) begin
      case (st_reg)
        wake_pm_pkg::SCAN_ADDR: begin
          if (rx_data == sa_byte(station_address, sel_reg)) begin
            if (idx_reg == `SA_COPIES_BYTES - 7'h01) begin
              found_next = 1'b1;
              st_next    = wake_pm_pkg::SCAN_IDLE;
            end
            idx_next = idx_reg + 7'h01;
            sel_next = (sel_reg == `SA_BYTES - 3'h1) ? 3'h0 : sel_reg + 3'h1;
          end else begin
            // Broken copy: this byte may itself start a new sync run
            cnt_next = (rx_data == `SYNC_BYTE) ? 3'h1 : 3'h0;
            st_next  = (rx_data == `SYNC_BYTE) ? wake_pm_pkg::SCAN_SYNC
                                               : wake_pm_pkg::SCAN_IDLE;
          end
        end
        default: begin
          if (rx_data == `SYNC_BYTE) begin
            st_next  = wake_pm_pkg::SCAN_SYNC;
            cnt_next = (cnt_reg == `SYNC_COUNT) ? cnt_reg : cnt_reg + 3'h1;
          end else if (cnt_reg == `SYNC_COUNT &&
                       rx_data == sa_byte(station_address, 3'h0)) begin
            st_next  = wake_pm_pkg::SCAN_ADDR;
            idx_next = 7'h01;
            sel_next = 3'h1;
          end else begin
            st_next  = wake_pm_pkg::SCAN_IDLE;
            cnt_next = 3'h0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg    <= wake_pm_pkg::SCAN_IDLE;
      cnt_reg   <= 3'h0;
      idx_reg   <= 7'h00;
      sel_reg   <= 3'h0;
      found_reg <= 1'b0;
      match     <= 1'b0;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      idx_reg   <= idx_next;
      sel_reg   <= sel_next;
      found_reg <= found_next;
      match     <= match_next;
    end
  end

  a_match_needs_crc: assert property (@(posedge clk) disable iff (sys_rst)
    match |-> $past(rx_eof) && $past(rx_crc_ok)
    && $past(addr_pass))
    else $error("match without good frame end");
endmodule

/* design/wake_power_manager.sv */
// Wake-frame detection and low-power control of the network controller
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "wake_pm_regs.svh"
module wake_power_manager #(
  parameter bit EARLY_STEP = 1'b1
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // EEPROM load stream
  input  wire logic        ee_valid,
  input  wire logic [5:0]  ee_word,
  input  wire logic [15:0] ee_data,
  input  wire logic        ee_done,
  // Receive stream and filter results
  input  wire logic        rx_sof,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_eof,
  input  wire logic        rx_crc_ok,
  input  wire logic        rx_addr_match,
  input  wire logic        rx_activity,
  // Low-power pin
  input  wire logic        flash_data_low_power_pin,
  // Power-management outputs
  output logic             pme_n,
  output logic             rx_to_memory,
  output logic             rx_drop,
  output logic             tx_enable,
  output logic             cmd_enable,
  output logic             bus_master_enable,
  output logic             irq_enable,
  output logic             pci_isolate,
  output logic             phy_low_power,
  output logic             activity_indicator_n
);
  wake_pm_pkg::pm_state_t pm_state_reg, pm_state_next;
  logic        wake_event_enable_reg, wake_event_enable_next;
  logic        evt_stat_reg, evt_stat_next;
  logic        cfg_addr_reg, cfg_addr_next;
  logic        cfg_pat_reg, cfg_pat_next;
  logic        standalone_wake_mode_reg, standalone_wake_mode_next;
  logic        armed_reg, armed_next;
  logic [31:0] rdata_next;
  logic        sa_we;
  logic [1:0]  sa_word;
  logic [15:0] sa_data;
  logic [47:0] station_address;
  logic        pat_match;
  logic        addr_hit;
  logic        wake_hit;
  logic        evt_set;
  logic        evt_clr;
  logic        low_power;
  logic        pin_lp;

  // Station address: EEPROM load wins over a bus write in the same cycle
  always_comb begin
    sa_we   = 1'b0;
    sa_word = 2'h0;
    sa_data = reg_wdata[15:0];
    if (ee_valid && ee_word <= `EE_SA_LAST) begin
      sa_we   = 1'b1;
      sa_word = ee_word[1:0];
      sa_data = ee_data;
    end else if (reg_wr) begin
      if (reg_addr == `SA0_OFS) begin
        sa_we   = 1'b1;
        sa_word = 2'h0;
      end else if (reg_addr == `SA1_OFS) begin
        sa_we   = 1'b1;
        sa_word = 2'h1;
      end else if (reg_addr == `SA2_OFS) begin
        sa_we   = 1'b1;
        sa_word = 2'h2;
      end
    end
  end

  station_addr_store u_sa (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (sa_we),
    .wr_word (sa_word),
    .wr_data (sa_data),
    .addr_q  (station_address)
  );

  pattern_matcher u_pm (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .rx_sof          (rx_sof),
    .rx_valid        (rx_valid),
    .rx_data         (rx_data),
    .rx_eof          (rx_eof),
    .rx_crc_ok       (rx_crc_ok),
    .addr_pass       (rx_addr_match),
    .station_address (station_address),
    .match           (pat_match)
  );

  // Low-power condition
  always_comb begin
    pin_lp    = EARLY_STEP & standalone_wake_mode_reg
              & flash_data_low_power_pin;
    low_power = (pm_state_reg != wake_pm_pkg::PS_D0) | pin_lp;
  end

  // Wake qualification
  always_comb begin
    addr_hit = cfg_addr_reg & rx_eof & rx_crc_ok & rx_addr_match;
    wake_hit = addr_hit | (cfg_pat_reg & pat_match);
    // No state check here: D0 hits count too
    if (standalone_wake_mode_reg) begin
      evt_set = armed_reg & pat_match;
    end else begin
      evt_set = wake_event_enable_reg & wake_hit;
    end
    evt_clr = reg_wr && reg_wdata[`EVT_STAT_BIT] &&
              (reg_addr == `PMCS_OFS || reg_addr == `GCS_OFS);
  end

  // Control and status registers
  always_comb begin
    pm_state_next             = pm_state_reg;
    wake_event_enable_next    = wake_event_enable_reg;
    cfg_addr_next             = cfg_addr_reg;
    cfg_pat_next              = cfg_pat_reg;
    standalone_wake_mode_next = standalone_wake_mode_reg;
    armed_next                = armed_reg;
    // Set beats clear so an event in the clearing cycle survives
    evt_stat_next = evt_set | (evt_stat_reg & ~evt_clr);
    if (ee_valid && ee_word == `EE_WAKE_WORD) begin
      standalone_wake_mode_next = ee_data[`EE_WAKE_BIT];
    end
    if (ee_done && standalone_wake_mode_reg) begin
      armed_next = 1'b1;
    end
    if (reg_wr) begin
      if (reg_addr == `PMCS_OFS) begin
        pm_state_next = wake_pm_pkg::pm_state_t'(
          reg_wdata[`PMCS_STATE_LSB +: 2]);
        wake_event_enable_next = reg_wdata[`PMCS_EN_BIT];
      end else if (reg_addr == `WCFG_OFS) begin
        cfg_addr_next = reg_wdata[`WCFG_ADDR_BIT];
        cfg_pat_next  = reg_wdata[`WCFG_PAT_BIT];
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdata_next = 32'h00000000;
    if (reg_rd) begin
      if (reg_addr == `PMCS_OFS) begin
        rdata_next[`PMCS_STATE_LSB +: 2] = pm_state_reg;
        rdata_next[`PMCS_EN_BIT]         = wake_event_enable_reg;
        rdata_next[`EVT_STAT_BIT]        = evt_stat_reg;
      end else if (reg_addr == `GCS_OFS) begin
        rdata_next[`GCS_SAW_BIT]  = standalone_wake_mode_reg;
        rdata_next[`GCS_LP_BIT]   = low_power;
        rdata_next[`GCS_ARM_BIT]  = armed_reg;
        rdata_next[`EVT_STAT_BIT] = evt_stat_reg;
      end else if (reg_addr == `WCFG_OFS) begin
        rdata_next[`WCFG_ADDR_BIT] = cfg_addr_reg;
        rdata_next[`WCFG_PAT_BIT]  = cfg_pat_reg;
      end else if (reg_addr == `SA0_OFS) begin
        rdata_next[15:0] = station_address[15:0];
      end else if (reg_addr == `SA1_OFS) begin
        rdata_next[15:0] = station_address[31:16];
      end else if (reg_addr == `SA2_OFS) begin
        rdata_next[15:0] = station_address[47:32];
      end
    end
  end

  // Reset leaves D0 with all wake filtering off
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pm_state_reg             <= wake_pm_pkg::PS_D0;
      wake_event_enable_reg    <= 1'b0;
      evt_stat_reg             <= 1'b0;
      cfg_addr_reg             <= 1'b0;
      cfg_pat_reg              <= 1'b0;
      standalone_wake_mode_reg <= 1'b0;
      armed_reg                <= 1'b0;
      reg_rdata                <= 32'h00000000;
    end else begin
      pm_state_reg             <= pm_state_next;
      wake_event_enable_reg    <= wake_event_enable_next;
      evt_stat_reg             <= evt_stat_next;
      cfg_addr_reg             <= cfg_addr_next;
      cfg_pat_reg              <= cfg_pat_next;
      standalone_wake_mode_reg <= standalone_wake_mode_next;
      armed_reg                <= armed_next;
      reg_rdata                <= rdata_next;
    end
  end

  // Pin outputs, all registered
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pme_n                <= 1'b1;
      rx_to_memory         <= 1'b1;
      rx_drop              <= 1'b0;
      tx_enable            <= 1'b1;
      cmd_enable           <= 1'b1;
      bus_master_enable    <= 1'b1;
      irq_enable           <= 1'b1;
      pci_isolate          <= 1'b0;
      phy_low_power        <= 1'b0;
      activity_indicator_n <= 1'b1;
    end else begin
      pme_n             <= ~evt_stat_next;
      // Delivery is refused in low power yet reception continues
      rx_to_memory      <= ~low_power
                           & ~standalone_wake_mode_next;
      // Pattern frame is known only at its end, so it is flushed then
      rx_drop           <= pat_match;
      tx_enable         <= ~low_power;
      cmd_enable        <= ~low_power;
      bus_master_enable <= ~low_power;
      irq_enable        <= ~low_power;
      pci_isolate       <= low_power;
      phy_low_power     <= pin_lp;
      if (standalone_wake_mode_reg) begin
        activity_indicator_n <= ~(rx_eof & rx_crc_ok
                                  & rx_addr_match);
      end else begin
        activity_indicator_n <= ~rx_activity;
      end
    end
  end

  a_wake_gated_en: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(evt_stat_reg) && !$past(standalone_wake_mode_reg)
    |-> $past(wake_event_enable_reg))
    else $error("wake status set with enable low");
  a_wake_in_d0: assert property (@(posedge clk) disable iff (sys_rst)
    !standalone_wake_mode_reg && wake_event_enable_reg && addr_hit
    |=> evt_stat_reg && !pme_n)
    else $error("enabled wake hit not signalled");
  a_status_holds: assert property (@(posedge clk) disable iff (sys_rst)
    evt_stat_reg && !evt_clr |=> evt_stat_reg)
    else $error("wake status dropped without clear");
  a_set_beats_clr: assert property (@(posedge clk) disable iff (sys_rst)
    evt_set && evt_clr |=> evt_stat_reg && !pme_n)
    else $error("event lost in clearing cycle");
  a_standalone_pme: assert property (@(posedge clk) disable iff (sys_rst)
    standalone_wake_mode_reg && armed_reg && pat_match
    |=> evt_stat_reg)
    else $error("standalone pattern did not raise status");
  a_ee_mode_bit: assert property (@(posedge clk) disable iff (sys_rst)
    ee_valid && ee_word == `EE_WAKE_WORD
    |=> standalone_wake_mode_reg == $past(ee_data[`EE_WAKE_BIT]))
    else $error("wake mode bit not taken from eeprom");
  a_lp_no_tx: assert property (@(posedge clk) disable iff (sys_rst)
    low_power |=> !tx_enable && !cmd_enable && !bus_master_enable
    && pci_isolate)
    else $error("activity allowed in low power");
  a_lp_no_rx_mem: assert property (@(posedge clk) disable iff (sys_rst)
    pm_state_reg != wake_pm_pkg::PS_D0 |=> !rx_to_memory)
    else $error("frame delivery in low power");
  a_pattern_drop: assert property (@(posedge clk) disable iff (sys_rst)
    pat_match |=> rx_drop)
    else $error("pattern frame not dropped");
  a_act_filtered: assert property (@(posedge clk) disable iff (sys_rst)
    standalone_wake_mode_reg && !rx_addr_match |=> activity_indicator_n)
    else $error("activity shown without filter hit");
endmodule

/* verif/host_pm_model.sv */
// Host-side register master that powers the device up and down
// Bus is modelled as always valid, so isolation is never requested
// Receive stream stays driven throughout low power
`timescale 1ns/1ns
`include "wake_pm_regs.svh"
module host_pm_model (
  // Clock
  input  wire logic        clk,
  // Register port toward the device
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Address first, so low power never runs on a blank address
  task automatic init_station(input logic [47:0] sa);
    wr(`SA0_OFS, {16'h0000, sa[15:0]});
    wr(`SA1_OFS, {16'h0000, sa[31:16]});
    wr(`SA2_OFS, {16'h0000, sa[47:32]});
  endtask

  // Enable is only ever raised once the device sits in D1
  task automatic arm_in_d1;
    wr(`PMCS_OFS, 32'h00000001);
    wr(`PMCS_OFS, 32'h00000001 | (32'h1 << `PMCS_EN_BIT));
  endtask
endmodule

/* verif/tb.sv */
// Self-checking bench for the wake and power manager
`timescale 1ns/1ns
`include "wake_pm_regs.svh"
module tb;
  localparam logic [47:0] SA  = 48'h665544332211;
  localparam logic [31:0] EVT = 32'h1 << `EVT_STAT_BIT;
  localparam logic [31:0] EN  = 32'h1 << `PMCS_EN_BIT;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        ee_valid = 1'b0;
  logic [5:0]  ee_word = 6'h00;
  logic [15:0] ee_data = 16'h0000;
  logic        ee_done = 1'b0;
  logic        rx_sof = 1'b0;
  logic        rx_valid = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic        rx_eof = 1'b0;
  logic        rx_crc_ok = 1'b0;
  logic        rx_addr_match = 1'b0;
  logic        rx_activity = 1'b0;
  logic        lp_pin = 1'b0;
  logic        pme_n, rx_to_memory, rx_drop, tx_enable, cmd_enable;
  logic        bus_master_enable, irq_enable, pci_isolate, phy_low_power;
  logic        activity_indicator_n;
  logic [31:0] d;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          n_drop = 0;
  int          n_act = 0;
  int          k0;

  always #5 clk = ~clk;

  wake_power_manager #(.EARLY_STEP(1'b1)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ee_valid(ee_valid), .ee_word(ee_word),
    .ee_data(ee_data), .ee_done(ee_done), .rx_sof(rx_sof),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_eof(rx_eof),
    .rx_crc_ok(rx_crc_ok), .rx_addr_match(rx_addr_match),
    .rx_activity(rx_activity), .flash_data_low_power_pin(lp_pin),
    .pme_n(pme_n), .rx_to_memory(rx_to_memory), .rx_drop(rx_drop),
    .tx_enable(tx_enable), .cmd_enable(cmd_enable),
    .bus_master_enable(bus_master_enable), .irq_enable(irq_enable),
    .pci_isolate(pci_isolate), .phy_low_power(phy_low_power),
    .activity_indicator_n(activity_indicator_n));

  host_pm_model u_host (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // Pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge clk) begin
    if (rx_drop === 1'b1)
      n_drop++;
    if (activity_indicator_n === 1'b0)
      n_act++;
    cycles++;
    if (cycles == 8000) begin
      n_mismatch++;
      end_sim;
    end
  end

  task automatic end_sim;
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task automatic do_reset;
    sys_rst = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  task automatic ee_put(input logic [5:0] w, input logic [15:0] v);
    @(posedge clk);
    ee_valid <= 1'b1;
    ee_word  <= w;
    ee_data  <= v;
    @(posedge clk);
    ee_valid <= 1'b0;
  endtask

  // Two filler bytes, sync run, sixteen address copies, then frame end
  task automatic send_frame(input bit brk, input logic crc, input logic am);
    logic [7:0] q[$];
    int         i;
    q = {8'h12, 8'h34};
    for (i = 0; i < 6; i++)
      q.push_back((brk && i == 2) ? 8'h00 : `SYNC_BYTE);
    for (i = 0; i < 96; i++)
      q.push_back(SA[8*(i%6) +: 8]);
    @(posedge clk);
    rx_sof      <= 1'b1;
    rx_activity <= 1'b1;
    foreach (q[k]) begin
      @(posedge clk);
      rx_sof   <= 1'b0;
      rx_valid <= 1'b1;
      rx_data  <= q[k];
    end
    @(posedge clk);
    rx_valid      <= 1'b0;
    rx_eof        <= 1'b1;
    rx_crc_ok     <= crc;
    rx_addr_match <= am;
    @(posedge clk);
    rx_eof        <= 1'b0;
    rx_crc_ok     <= 1'b0;
    rx_addr_match <= 1'b0;
    rx_activity   <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // Pattern cases: break, crc, filter hit, expected event
  logic [3:0] pat_tab [4] = '{4'b0111, 4'b1110, 4'b0010, 4'b0100};

  initial begin
    do_reset;
    u_host.rd(`PMCS_OFS, d);
    chk(d, 32'h0);
    u_host.rd(`GCS_OFS, d);
    chk(d, 32'h0);
    u_host.rd(8'hFC, d);
    chk(d, 32'h0);
    chk({pme_n, tx_enable, rx_to_memory, phy_low_power}, 4'hE);
    u_host.init_station(SA);
    u_host.wr(`WCFG_OFS, 32'h1 << `WCFG_ADDR_BIT);
    send_frame(1'b0, 1'b1, 1'b1);
    chk(pme_n, 1'b1);
    u_host.arm_in_d1;
    repeat (2) @(posedge clk);
    chk({tx_enable, cmd_enable, rx_to_memory}, 3'h0);
    chk({bus_master_enable, irq_enable, pci_isolate}, 3'h1);
    u_host.wr(`PMCS_OFS, EN);
    send_frame(1'b0, 1'b1, 1'b1);
    chk(pme_n, 1'b0);
    u_host.rd(`PMCS_OFS, d);
    chk(d, EN | EVT);
    repeat (20) @(posedge clk);
    u_host.rd(`GCS_OFS, d);
    chk(d & EVT, EVT);
    chk(pme_n, 1'b0);
    u_host.wr(`GCS_OFS, EVT);
    repeat (2) @(posedge clk);
    chk(pme_n, 1'b1);
    u_host.wr(`WCFG_OFS, 32'h1 << `WCFG_PAT_BIT);
    for (k0 = 0; k0 < 4; k0++) begin
      d = n_drop;
      send_frame(pat_tab[k0][3], pat_tab[k0][2], pat_tab[k0][1]);
      // Concatenation keeps the inversion one bit wide
      chk({31'h0, ~pme_n}, pat_tab[k0][0]);
      chk(n_drop - d, pat_tab[k0][0]);
      u_host.wr(`PMCS_OFS, EN | EVT);
    end
    do_reset;
    for (k0 = 0; k0 < 3; k0++)
      ee_put(k0[5:0], SA[16*k0 +: 16]);
    ee_put(`EE_WAKE_WORD, 16'h1 << `EE_WAKE_BIT);
    @(posedge clk);
    ee_done <= 1'b1;
    @(posedge clk);
    ee_done <= 1'b0;
    u_host.rd(`GCS_OFS, d);
    chk(d & 32'h1, 32'h1 << `GCS_SAW_BIT);
    d = n_act;
    send_frame(1'b0, 1'b1, 1'b0);
    chk(n_act - d, 32'h0);
    send_frame(1'b0, 1'b1, 1'b1);
    chk(pme_n, 1'b0);
    chk(n_act - d, 32'h1);
    lp_pin <= 1'b1;
    repeat (3) @(posedge clk);
    chk(phy_low_power, 1'b1);
    u_host.rd(`GCS_OFS, d);
    chk(d & (32'h1 << `GCS_LP_BIT), 32'h1 << `GCS_LP_BIT);
    end_sim;
  end
endmodule
